// ---- hw/cdr_pkg.sv ----
// Constants, register map and field layout for the current-detect register bank.
// Assumes APB with 32-bit data, one aligned word per register.
// Contract
// [R1] Trigger count code n means 2^n exceedances
// [R2] Length code maps 128..3584 conversion periods
// [R3] Enable bit 0 gates detect mode
// [R4] Threshold high word holds bits 23:8
// [R5] Low word bits 15:8 hold threshold 7:0
// [R6] Threshold words reset to zero
// [R7] DC-removal setting bits 3:0, applied unless bypassed
// [R8] Channel 0 phase delay bits 15:6
// [R9] Bit 2 bypasses channel 0 DC removal
// [R10] Two-bit channel 0 input selector
// [R11] Channel 0 config at 09h, reset zero
// [R12] Bit 7 selects any or all channels
// [R13] Reserved bits read zero, ignore writes
// [R14] Settings change restarts measurement and count
package cdr_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int NUM_CH = 8;
  // Printed offsets are word indices; byte address is four times
  localparam logic [ADDR_W-1:0] IDX_CFG = 8'h06;
  localparam logic [ADDR_W-1:0] IDX_TH_HI = 8'h07;
  localparam logic [ADDR_W-1:0] IDX_TH_LO = 8'h08;
  localparam logic [ADDR_W-1:0] IDX_CH0 = 8'h09;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STAT = 8'h20;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 8'h21;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 8'h22;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] TH_HI_RST = 16'h0000;
  localparam logic [15:0] TH_LO_RST = 16'h0000;
  localparam logic [15:0] CH0_RST = 16'h0000;
  // Writable masks; zero bits are reserved
  localparam logic [15:0] CFG_WMASK = 16'h00ff;
  localparam logic [15:0] TH_LO_WMASK = 16'hff0f;
  localparam logic [15:0] CH0_WMASK = 16'hffc7;
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_LEN_LSB = 1;
  localparam int CFG_NUM_LSB = 4;
  localparam int CFG_ALL_BIT = 7;
  localparam int TH_LO_TH_LSB = 8;
  localparam int TH_LO_DC_LSB = 0;
  localparam int CH0_PH_LSB = 6;
  localparam int CH0_BYP_BIT = 2;
  localparam int CH0_MUX_LSB = 0;
  localparam int IRQ_DETECT_BIT = 0;
  localparam int IRQ_CFGCHG_BIT = 1;
  localparam int IRQ_W = 2;
  localparam int LEN_W = 12;
  localparam int CNT_W = 8;
  // Input selector codes
  localparam logic [1:0] MUX_PINS = 2'h0;
  localparam logic [1:0] MUX_SHORT = 2'h1;
  localparam logic [1:0] MUX_POS_TEST = 2'h2;
  localparam logic [1:0] MUX_NEG_TEST = 2'h3;
  // Measurement length in conversion periods, indexed by code
  function automatic logic [LEN_W-1:0] cdr_len_periods(input logic [2:0] code);
    logic [LEN_W-1:0] v;
    v = 12'h080;
    unique case (code)
      3'h0: v = 12'h080;
      3'h1: v = 12'h100;
      3'h2: v = 12'h200;
      3'h3: v = 12'h300;
      3'h4: v = 12'h500;
      3'h5: v = 12'h700;
      3'h6: v = 12'ha00;
      3'h7: v = 12'he00;
    endcase
    return v;
  endfunction
endpackage

// ---- hw/cdr_exceed_counter.sv ----
// Counts threshold exceedances within one measurement window.
// Assumes a one-cycle conversion strobe from the same clock.
`timescale 1ns/1ps
`default_nettype none
module cdr_exceed_counter
  import cdr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Control
  input wire logic restart,
  input wire logic [2:0] triggerCode,
  // Events
  input wire logic exceed,
  output logic reached
);
  typedef struct packed {
    logic [CNT_W:0] count;
  } cdr_cnt_st_t;
  cdr_cnt_st_t r, next_r;
  logic [CNT_W:0] target;
  always_comb begin
    target = (CNT_W+1)'(1) << triggerCode; // [R1]
    next_r = r;
    if (restart) begin
      next_r.count = '0; // [R14]
    end else if (exceed && r.count < target) begin
      next_r.count = r.count + (CNT_W+1)'(1);
    end
    reached = (r.count >= target);
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else if (clkEn) begin
      r <= next_r;
    end
  end
endmodule
`default_nettype wire

// ---- hw/cdr_window_timer.sv ----
// Measurement window timer in conversion periods.
// Assumes a one-cycle conversion strobe from the same clock.
`timescale 1ns/1ps
`default_nettype none
module cdr_window_timer
  import cdr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Control
  input wire logic run,
  input wire logic restart,
  input wire logic [2:0] lengthCode,
  input wire logic convStrobe,
  // Status
  output logic windowEnd
);
  typedef struct packed {
    logic [LEN_W-1:0] elapsed;
  } cdr_tmr_st_t;
  cdr_tmr_st_t r, next_r;
  logic [LEN_W-1:0] limit;
  always_comb begin
    limit = cdr_len_periods(lengthCode); // [R2]
    next_r = r;
    windowEnd = 1'b0;
    if (restart || !run) begin
      next_r.elapsed = '0;
    end else if (convStrobe) begin
      if (r.elapsed == limit - LEN_W'(1)) begin
        windowEnd = 1'b1;
        next_r.elapsed = '0;
      end else begin
        next_r.elapsed = r.elapsed + LEN_W'(1);
      end
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else if (clkEn) begin
      r <= next_r;
    end
  end
endmodule
`default_nettype wire

// ---- hw/cdr_regs.sv ----
// Current-detect and channel 0 configuration register bank, APB slave.
// Assumes per-channel exceed flags and conversion strobe on mclk.
`timescale 1ns/1ps
`default_nettype none
module cdr_regs
  import cdr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cdr_pkg::ADDR_W+1:0] paddr,
  input wire logic [cdr_pkg::DATA_W-1:0] pwdata,
  output logic [cdr_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Datapath
  input wire logic convStrobe,
  input wire logic [cdr_pkg::NUM_CH-1:0] chanExceed,
  // Configuration and status outputs
  output logic detectModeEnable,
  output logic [23:0] detectThreshold,
  output logic [3:0] dcRemovalSetting,
  output logic chanZeroDcRemovalActive,
  output logic [9:0] chanZeroPhaseDelay,
  output logic [1:0] chanZeroInputSelect,
  output logic currentDetected,
  output logic irq
);
  import cdr_pkg::*;
  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] thHi;
    logic [15:0] thLo;
    logic [15:0] ch0;
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqMask;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic detected;
    logic irq;
    logic [NUM_CH-1:0] exceedQ;
    logic convQ;
  } cdr_st_t;
  cdr_st_t r, next_r;
  logic [ADDR_W-1:0] idx;
  logic setup, wrAcc, rdAcc, mapped, cfgChange, restart, anyReached, allReached, winEnd;
  logic [15:0] wv;
  logic [NUM_CH-1:0] reached;
  logic [IRQ_W-1:0] irqEvt;
  cdr_window_timer u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .run(r.cfg[CFG_EN_BIT]),
    .restart(restart),
    .lengthCode(r.cfg[CFG_LEN_LSB +: 3]),
    .convStrobe(r.convQ),
    .windowEnd(winEnd)
  );
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      cdr_exceed_counter u_cnt (
        .mclk(mclk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .restart(restart || winEnd),
        .triggerCode(r.cfg[CFG_NUM_LSB +: 3]),
        .exceed(r.exceedQ[g] && r.convQ),
        .reached(reached[g])
      );
    end
  endgenerate
  always_comb begin
    next_r = r;
    idx = paddr[ADDR_W+1:2];
    setup = psel && !penable;
    wrAcc = psel && penable && pwrite && r.pready;
    rdAcc = setup && !pwrite;
    wv = pwdata[15:0];
    mapped = (idx == IDX_CFG) || (idx == IDX_TH_HI) || (idx == IDX_TH_LO) ||
             (idx == IDX_CH0) || (idx == IDX_IRQ_STAT) || (idx == IDX_IRQ_MASK) ||
             (idx == IDX_STATUS);
    cfgChange = 1'b0;
    next_r.exceedQ = chanExceed;
    next_r.convQ = convStrobe;
    // No wait state: ready rises in the cycle after setup
    next_r.pready = setup;
    next_r.pslverr = setup && !mapped;
    if (rdAcc) begin
      next_r.prdata = '0;
      unique case (idx)
        IDX_CFG: next_r.prdata[15:0] = r.cfg;
        IDX_TH_HI: next_r.prdata[15:0] = r.thHi; // [R4]
        IDX_TH_LO: next_r.prdata[15:0] = r.thLo & TH_LO_WMASK; // [R13]
        IDX_CH0: next_r.prdata[15:0] = r.ch0 & CH0_WMASK; // [R13]
        IDX_IRQ_STAT: next_r.prdata[IRQ_W-1:0] = r.irqStat;
        IDX_IRQ_MASK: next_r.prdata[IRQ_W-1:0] = r.irqMask;
        IDX_STATUS: next_r.prdata[0] = r.detected;
        default: next_r.prdata = '0;
      endcase
    end
    if (wrAcc) begin
      unique case (idx)
        IDX_CFG: begin
          next_r.cfg = wv & CFG_WMASK;
          cfgChange = (next_r.cfg != r.cfg);
        end
        IDX_TH_HI: begin
          next_r.thHi = wv; // [R4]
          cfgChange = (wv != r.thHi);
        end
        IDX_TH_LO: begin
          next_r.thLo = wv & TH_LO_WMASK; // [R5] [R7] [R13]
          cfgChange = (wv[15:8] != r.thLo[15:8]);
        end
        IDX_CH0: next_r.ch0 = wv & CH0_WMASK; // [R11] [R13]
        IDX_IRQ_MASK: next_r.irqMask = pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    // Restart on a config or threshold change while enabled, and hold cleared while off
    restart = !r.cfg[CFG_EN_BIT] || (cfgChange && (r.cfg[CFG_EN_BIT] ||
              next_r.cfg[CFG_EN_BIT])); // [R3] [R14]
    anyReached = |reached;
    allReached = &reached;
    next_r.detected = 1'b0;
    if (r.cfg[CFG_EN_BIT] && !restart) begin // [R3]
      next_r.detected = r.cfg[CFG_ALL_BIT] ? allReached : anyReached; // [R12]
    end
    irqEvt = '0;
    irqEvt[IRQ_DETECT_BIT] = next_r.detected && !r.detected;
    irqEvt[IRQ_CFGCHG_BIT] = restart && r.cfg[CFG_EN_BIT];
    // Set wins over a write-one clear in the same cycle
    if (wrAcc && idx == IDX_IRQ_STAT) begin
      next_r.irqStat = (r.irqStat & ~pwdata[IRQ_W-1:0]) | irqEvt;
    end else begin
      next_r.irqStat = r.irqStat | irqEvt;
    end
    next_r.irq = |(next_r.irqStat & next_r.irqMask);
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.cfg <= CFG_RST;
      r.thHi <= TH_HI_RST; // [R6]
      r.thLo <= TH_LO_RST; // [R6]
      r.ch0 <= CH0_RST; // [R11]
    end else if (clkEn) begin
      r <= next_r;
    end
  end
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign detectModeEnable = r.cfg[CFG_EN_BIT];
  assign detectThreshold = {r.thHi, r.thLo[TH_LO_TH_LSB +: 8]}; // [R4] [R5]
  assign dcRemovalSetting = r.thLo[TH_LO_DC_LSB +: 4]; // [R7]
  assign chanZeroDcRemovalActive = !r.ch0[CH0_BYP_BIT]; // [R9]
  assign chanZeroPhaseDelay = r.ch0[CH0_PH_LSB +: 10]; // [R8]
  assign chanZeroInputSelect = r.ch0[CH0_MUX_LSB +: 2]; // [R10]
  assign currentDetected = r.detected;
  assign irq = r.irq;

  property p_th_reset;
    @(posedge mclk) $rose(rst_n) |-> detectThreshold == 24'h000000;
  endproperty
  a_th_reset: assert property (p_th_reset) else $error("threshold not zero"); // [R6]
  property p_ch0_reset;
    @(posedge mclk) $rose(rst_n) |-> r.ch0 == CH0_RST;
  endproperty
  a_ch0_reset: assert property (p_ch0_reset) else $error("ch0 not zero"); // [R11]
  property p_disabled;
    @(posedge mclk) disable iff (!rst_n) !detectModeEnable |-> ##1 !currentDetected;
  endproperty
  a_disabled: assert property (p_disabled) else $error("detect while off"); // [R3]
  property p_resv_read;
    @(posedge mclk) disable iff (!rst_n)
      pready && !pwrite && idx == IDX_CH0 |-> prdata[5:3] == 3'h0;
  endproperty
  a_resv_read: assert property (p_resv_read) else $error("reserved bits set"); // [R13]
  property p_th_lo_write;
    @(posedge mclk) disable iff (!rst_n)
      clkEn && wrAcc && idx == IDX_TH_LO |=> detectThreshold[7:0] == $past(pwdata[15:8]) &&
      dcRemovalSetting == $past(pwdata[3:0]);
  endproperty
  a_th_lo_write: assert property (p_th_lo_write) else $error("low word write lost"); // [R5]
  property p_th_hi_write;
    @(posedge mclk) disable iff (!rst_n)
      clkEn && wrAcc && idx == IDX_TH_HI |=> detectThreshold[23:8] == $past(pwdata[15:0]);
  endproperty
  a_th_hi_write: assert property (p_th_hi_write) else $error("high word write lost"); // [R4]
  property p_bypass;
    @(posedge mclk) disable iff (!rst_n)
      clkEn && wrAcc && idx == IDX_CH0 |=>
      chanZeroDcRemovalActive == !$past(pwdata[CH0_BYP_BIT]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass wrong"); // [R9]
  property p_restart;
    @(posedge mclk) disable iff (!rst_n)
      clkEn && restart |=> !currentDetected;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart"); // [R14]
  property p_allch;
    @(posedge mclk) disable iff (!rst_n)
      clkEn && r.cfg[CFG_ALL_BIT] && !allReached |=> !currentDetected;
  endproperty
  a_allch: assert property (p_allch) else $error("all-channel mode fired"); // [R12]
  property p_mux;
    @(posedge mclk) disable iff (!rst_n)
      clkEn && wrAcc && idx == IDX_CH0 |=> chanZeroInputSelect == $past(pwdata[1:0]) &&
      chanZeroPhaseDelay == $past(pwdata[15:6]);
  endproperty
  a_mux: assert property (p_mux) else $error("ch0 fields wrong"); // [R8] [R10]

  // Bus transfer steps; an access only counts once ready is seen
  sequence s_setup;
    clkEn && psel && !penable;
  endsequence
  sequence s_access;
    clkEn && psel && penable && pready;
  endsequence
  sequence s_read_setup;
    clkEn && psel && !penable && !pwrite;
  endsequence
  sequence s_bad_setup;
    clkEn && psel && !penable && !mapped;
  endsequence
  property p_rdy_setup;
    @(posedge mclk) disable iff (!rst_n) s_setup |=> pready;
  endproperty
  a_rdy_setup: assert property (p_rdy_setup) else $error("no ready after setup");
  property p_rdy_pulse;
    @(posedge mclk) disable iff (!rst_n) s_setup ##1 s_access |=> !pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready held too long");
  property p_bad_err;
    @(posedge mclk) disable iff (!rst_n) s_bad_setup |=> pslverr;
  endproperty
  a_bad_err: assert property (p_bad_err) else $error("unmapped access not refused");
  property p_good_err;
    @(posedge mclk) disable iff (!rst_n) s_setup ##0 mapped |=> !pslverr;
  endproperty
  a_good_err: assert property (p_good_err) else $error("mapped access refused");
  property p_bad_rdata;
    @(posedge mclk) disable iff (!rst_n) s_bad_setup ##0 !pwrite |=> prdata == '0;
  endproperty
  a_bad_rdata: assert property (p_bad_rdata) else $error("unmapped read not zero");
  property p_read_upper;
    @(posedge mclk) disable iff (!rst_n) s_read_setup |=> prdata[DATA_W-1:16] == 16'h0000;
  endproperty
  a_read_upper: assert property (p_read_upper) else $error("upper read bits set");
  property p_lo_resv;
    @(posedge mclk) disable iff (!rst_n)
      s_read_setup ##0 idx == IDX_TH_LO |=> prdata[7:4] == 4'h0;
  endproperty
  a_lo_resv: assert property (p_lo_resv) else $error("low word reserved bits set"); // [R13]
  property p_cfg_write;
    @(posedge mclk) disable iff (!rst_n)
      clkEn && wrAcc && idx == IDX_CFG |=> detectModeEnable == $past(pwdata[CFG_EN_BIT]);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("enable write lost"); // [R3]
  property p_restart_flag;
    @(posedge mclk) disable iff (!rst_n)
      clkEn && cfgChange && r.cfg[CFG_EN_BIT] |=> r.irqStat[IRQ_CFGCHG_BIT];
  endproperty
  a_restart_flag: assert property (p_restart_flag) else $error("restart not flagged"); // [R14]
  // A rise must leave its flag set even if a clear lands in the same cycle
  property p_detect_flag;
    @(posedge mclk) disable iff (!rst_n)
      clkEn && !currentDetected ##1 currentDetected |-> r.irqStat[IRQ_DETECT_BIT];
  endproperty
  a_detect_flag: assert property (p_detect_flag) else $error("detection not flagged");
  property p_irq_level;
    @(posedge mclk) disable iff (!rst_n) clkEn |=> irq == |(r.irqStat & r.irqMask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong");
  property p_restart_clear;
    @(posedge mclk) disable iff (!rst_n) clkEn && restart |=> reached == '0;
  endproperty
  a_restart_clear: assert property (p_restart_clear) else $error("counts not cleared"); // [R14]
  property p_trig_one;
    @(posedge mclk) disable iff (!rst_n)
      clkEn && !restart && !winEnd && r.cfg[CFG_NUM_LSB +: 3] == 3'h0 &&
      r.exceedQ[0] && r.convQ |=> reached[0];
  endproperty
  a_trig_one: assert property (p_trig_one) else $error("single exceedance missed"); // [R1]
  property p_any_detect;
    @(posedge mclk) disable iff (!rst_n)
      clkEn && r.cfg[CFG_EN_BIT] && !restart && !r.cfg[CFG_ALL_BIT] && anyReached |=>
      currentDetected;
  endproperty
  a_any_detect: assert property (p_any_detect) else $error("any-channel detect missed"); // [R12]
  property p_all_detect;
    @(posedge mclk) disable iff (!rst_n)
      clkEn && r.cfg[CFG_EN_BIT] && !restart && r.cfg[CFG_ALL_BIT] && allReached |=>
      currentDetected;
  endproperty
  a_all_detect: assert property (p_all_detect) else $error("all-channel detect missed"); // [R12]
endmodule
`default_nettype wire

// ---- tb/test_cdr_regs.sv ----
// Self-checking bench for the current-detect register bank.
// Assumes only the bench drives the block's inputs.
`timescale 1ns/1ps
`default_nettype none
module test_cdr_regs;
  import cdr_pkg::*;
  logic mclk, rst_n, clkEn, psel, penable, pwrite, convStrobe;
  logic [ADDR_W+1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rdat;
  logic pready, pslverr, rerr;
  logic [NUM_CH-1:0] chanExceed;
  logic detectModeEnable, chanZeroDcRemovalActive, currentDetected, irq;
  logic [23:0] detectThreshold;
  logic [3:0] dcRemovalSetting;
  logic [9:0] chanZeroPhaseDelay;
  logic [1:0] chanZeroInputSelect;
  logic [7:0] idxList [4];
  int fails = 0;
  int n_tests = 0;

  cdr_regs dut_u (
    .mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .convStrobe(convStrobe), .chanExceed(chanExceed),
    .detectModeEnable(detectModeEnable), .detectThreshold(detectThreshold),
    .dcRemovalSetting(dcRemovalSetting), .chanZeroDcRemovalActive(chanZeroDcRemovalActive),
    .chanZeroPhaseDelay(chanZeroPhaseDelay), .chanZeroInputSelect(chanZeroInputSelect),
    .currentDetected(currentDetected), .irq(irq)
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // Waits for pready, whatever its latency
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk);
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    check(rdat, exp);
  endtask
  task automatic strobe(input logic [7:0] ex, input int n);
    repeat (n) begin
      @(posedge mclk);
      convStrobe <= 1'b1;
      chanExceed <= ex;
      @(posedge mclk);
      convStrobe <= 1'b0;
      chanExceed <= 8'h00;
    end
    repeat (6) @(posedge mclk);
  endtask
  initial begin
    #100000;
    fails++;
    test_done();
  end

  initial begin
    {psel, penable, pwrite, convStrobe} = 4'h0;
    paddr = '0;
    pwdata = '0;
    chanExceed = '0;
    clkEn = 1'b1;
    rst_n = 1'b0;
    idxList = '{IDX_CFG, IDX_TH_HI, IDX_TH_LO, IDX_CH0};
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (idxList[i]) rdchk(idxList[i], 32'h0);
    check({detectModeEnable, detectThreshold, dcRemovalSetting}, 32'h0);
    check({chanZeroPhaseDelay, chanZeroInputSelect}, 32'h0);
    $display("reset test done");

    apb(1'b1, IDX_TH_HI, 32'h0000a5c3);
    apb(1'b1, IDX_TH_LO, 32'hffffffff);
    rdchk(IDX_TH_LO, 32'h0000ff0f);
    check(detectThreshold, 32'ha5c3ff);
    check(dcRemovalSetting, 32'hf);
    apb(1'b1, IDX_CH0, 32'h0000ffff);
    rdchk(IDX_CH0, 32'h0000ffc7);
    check(chanZeroPhaseDelay, 32'h3ff);
    check(chanZeroDcRemovalActive, 32'h0);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, IDX_CH0, 32'h00005540 | m);
      @(posedge mclk);
      check({chanZeroPhaseDelay, chanZeroInputSelect}, (32'h155 << 2) | m);
      check(chanZeroDcRemovalActive, 32'h1);
    end
    apb(1'b0, 8'h3f, 32'h0);
    check(rerr, 32'h1);
    check(rdat, 32'h0);
    $display("field test done");

    apb(1'b1, IDX_IRQ_STAT, 32'h3);
    apb(1'b1, IDX_CFG, 32'h20);
    strobe(8'hff, 4);
    check(currentDetected, 32'h0);
    apb(1'b1, IDX_CFG, 32'h21);
    strobe(8'h08, 3);
    check(detectModeEnable, 32'h1);
    check(currentDetected, 32'h0);
    strobe(8'h08, 1);
    check(currentDetected, 32'h1);
    check(irq, 32'h0);
    apb(1'b0, IDX_IRQ_STAT, 32'h0);
    check(rdat & 32'h1, 32'h1);
    apb(1'b1, IDX_IRQ_MASK, 32'h1);
    repeat (2) @(posedge mclk);
    check(irq, 32'h1);
    apb(1'b1, IDX_IRQ_STAT, 32'h1);
    repeat (2) @(posedge mclk);
    check(irq, 32'h0);
    $display("detect test done");

    apb(1'b1, IDX_CFG, 32'h0);
    apb(1'b1, IDX_IRQ_STAT, 32'h3);
    apb(1'b1, IDX_CFG, 32'h21);
    strobe(8'h08, 3);
    apb(1'b1, IDX_TH_HI, 32'h00001234);
    strobe(8'h08, 3);
    check(currentDetected, 32'h0);
    apb(1'b0, IDX_IRQ_STAT, 32'h0);
    check(rdat & 32'h2, 32'h2);
    $display("restart test done");

    // Old exceedances drop once the window closes
    apb(1'b1, IDX_CFG, 32'h0);
    apb(1'b1, IDX_CFG, 32'h21);
    strobe(8'h08, 3);
    strobe(8'h00, 130);
    strobe(8'h08, 3);
    check(currentDetected, 32'h0);
    $display("window test done");

    apb(1'b1, IDX_CFG, 32'h0);
    apb(1'b1, IDX_CFG, 32'h81);
    strobe(8'h01, 1);
    check(currentDetected, 32'h0);
    clkEn <= 1'b0;
    strobe(8'hff, 1);
    clkEn <= 1'b1;
    check(currentDetected, 32'h0);
    strobe(8'hff, 1);
    check(currentDetected, 32'h1);
    $display("all-channel test done");
    test_done();
  end
endmodule
`default_nettype wire
